// ### src/strobe_pkg.sv
// constants for the rail sequencer and strobe decoder
package strobe_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int OFFSET_DELAY_MS = 100;
   localparam int RAIL_GAP_MS = 10;
   localparam int OFFSET_DELAY_CYC = (CLK_HZ / 1000) * OFFSET_DELAY_MS;
   localparam int RAIL_GAP_CYC = (CLK_HZ / 1000) * RAIL_GAP_MS;
   localparam int CNT_W = 24;
   localparam int SW_N = 6;
   localparam int CODE_W = 10;
   localparam int BBM_W = 8;
   localparam logic [7:0] BBM_RESET = 8'h10;
   localparam logic [CODE_W-1:0] CODE_RESET = 10'h100;
   localparam logic [SW_N-1:0] SW_ALL_OPEN = 6'h00;
   // switch patterns, bit 0 is led_switch_one
   localparam logic [SW_N-1:0] MAP0_SEL0 = 6'h07;
   localparam logic [SW_N-1:0] MAP0_SEL1 = 6'h0F;
   localparam logic [SW_N-1:0] MAP0_SEL2 = 6'h17;
   localparam logic [SW_N-1:0] MAP0_SEL3 = 6'h27;
   localparam logic [SW_N-1:0] MAP1_SEL0 = 6'h00;
   localparam logic [SW_N-1:0] MAP1_SEL1 = 6'h21;
   localparam logic [SW_N-1:0] MAP1_SEL2 = 6'h1C;
   localparam logic [SW_N-1:0] MAP1_SEL3 = 6'h1A;
   // apb map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BBM = 8'h04;
   localparam logic [7:0] ADDR_CODE4 = 8'h08;
   localparam logic [7:0] ADDR_CODE5 = 8'h0C;
   localparam logic [7:0] ADDR_CODE6 = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam int CTRL_MAP_BIT = 0;
   localparam int CTRL_REG_EN_BIT = 1;
   localparam int CTRL_LED_EN_BIT = 2;
   typedef enum logic [2:0]
   {
      ST_OFF = 3'b000,
      ST_WAIT_OFS = 3'b001,
      ST_WAIT_REST = 3'b010,
      ST_ACTIVE = 3'b011,
      ST_FAULT = 3'b100
   } seq_state_t;
endpackage : strobe_pkg

// ### src/bbm_switch.sv
// break-before-make switch driver
`timescale 1ns/1ns
`default_nettype none
module bbm_switch
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [strobe_pkg::SW_N-1:0] target,
   input wire logic [strobe_pkg::BBM_W-1:0] dead_cycles,
   output logic [strobe_pkg::SW_N-1:0] sw_q,
   output logic busy
);
   logic [strobe_pkg::BBM_W-1:0] cnt_q;
   logic waiting_q;
   wire logic [strobe_pkg::SW_N-1:0] keep = sw_q & target;
   wire logic opening = (sw_q & ~target) != strobe_pkg::SW_ALL_OPEN;
   wire logic closing = (target & ~sw_q) != strobe_pkg::SW_ALL_OPEN;
   assign busy = waiting_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sw_q <= 6'h00;
         cnt_q <= 8'h00;
         waiting_q <= 1'b0;
      end
      else if (opening)
      begin
         sw_q <= keep;
         cnt_q <= dead_cycles;
         waiting_q <= 1'b1;
      end
      else if (waiting_q && cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
      else if (closing)
      begin
         sw_q <= target;
         waiting_q <= 1'b0;
      end
      else
         waiting_q <= 1'b0;
   end
endmodule : bbm_switch
`default_nettype wire

// ### src/strobe_sequencer.sv
// rail sequencer and rgb strobe decoder with apb registers
`timescale 1ns/1ns
`default_nettype none
module strobe_sequencer
#(
   // sequencing counts; defaults are the real delays, a bench may shorten them
   parameter int OFS_CYC = strobe_pkg::OFFSET_DELAY_CYC,
   parameter int GAP_CYC = strobe_pkg::RAIL_GAP_CYC
)
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic POWER_REQUEST_PIN,
   input wire logic [1:0] COLOUR_SELECT,
   input wire logic RAIL_FAULT,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic MIRROR_OFFSET_RAIL,
   output logic MIRROR_BIAS_RAIL,
   output logic MIRROR_RESET_RAIL,
   output logic LED_DRIVER_EN,
   output logic [5:0] LED_SWITCH,
   output logic [9:0] CURRENT_CODE,
   output logic CODE_VALID
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end
      else
      begin
         sync1_q <= {RAIL_FAULT, COLOUR_SELECT, POWER_REQUEST_PIN};
         sync2_q <= sync1_q;
      end
   end
   wire logic req = sync2_q[0];
   wire logic [1:0] sel = sync2_q[2:1];
   wire logic fault = sync2_q[3];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [2:0] ctrl_q;
   logic [7:0] bbm_q;
   logic [9:0] code4_q;
   logic [9:0] code5_q;
   logic [9:0] code6_q;
   logic [31:0] rdata_q;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   // read data is taken in setup so it stands by the access edge
   wire logic wr = PSEL && PENABLE && PWRITE;
   wire logic rd = PSEL && !PENABLE && !PWRITE;
   wire logic at_ctrl = PADDR == strobe_pkg::ADDR_CTRL;
   wire logic at_bbm = PADDR == strobe_pkg::ADDR_BBM;
   wire logic at_code4 = PADDR == strobe_pkg::ADDR_CODE4;
   wire logic at_code5 = PADDR == strobe_pkg::ADDR_CODE5;
   wire logic at_code6 = PADDR == strobe_pkg::ADDR_CODE6;
   wire logic at_status = PADDR == strobe_pkg::ADDR_STATUS;
   wire logic hit = at_ctrl || at_bbm || at_code4 || at_code5 || at_code6 || at_status;
   // writes land at the access edge only, never in setup
   wire logic wr_ctrl = wr && at_ctrl;
   wire logic wr_bbm = wr && at_bbm;
   wire logic wr_code4 = wr && at_code4;
   wire logic wr_code5 = wr && at_code5;
   wire logic wr_code6 = wr && at_code6;
   // no wait states: every access ends in one cycle
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !hit;
   assign PRDATA = rdata_q;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         ctrl_q <= 3'h6;
      else if (wr_ctrl)
         ctrl_q <= PWDATA[2:0];
   end

   // a new delay only affects the next switch change
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         bbm_q <= strobe_pkg::BBM_RESET;
      else if (wr_bbm)
         bbm_q <= PWDATA[7:0];
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         code4_q <= strobe_pkg::CODE_RESET;
      else if (wr_code4)
         code4_q <= PWDATA[9:0];
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         code5_q <= strobe_pkg::CODE_RESET;
      else if (wr_code5)
         code5_q <= PWDATA[9:0];
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         code6_q <= strobe_pkg::CODE_RESET;
      else if (wr_code6)
         code6_q <= PWDATA[9:0];
   end

   // ----------------------------------------
   // power sequence
   // ----------------------------------------
   strobe_pkg::seq_state_t state_q;
   logic [strobe_pkg::CNT_W-1:0] cnt_q;
   wire logic reg_en = ctrl_q[strobe_pkg::CTRL_REG_EN_BIT];
   wire logic led_en = ctrl_q[strobe_pkg::CTRL_LED_EN_BIT];
   wire logic cnt_done = cnt_q == 24'h000000;

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         state_q <= strobe_pkg::ST_OFF;
         cnt_q <= 24'h000000;
      end
      else if (!req || !reg_en)
      begin
         state_q <= strobe_pkg::ST_OFF;
         cnt_q <= 24'h000000;
      end
      // any fault drops all rails, latched until request toggles or reg_en is cleared
      else if (fault && state_q != strobe_pkg::ST_OFF)
         state_q <= strobe_pkg::ST_FAULT;
      else
      begin
         case (state_q)
            strobe_pkg::ST_OFF:
            begin
               state_q <= strobe_pkg::ST_WAIT_OFS;
               cnt_q <= strobe_pkg::CNT_W'(OFS_CYC - 1);
            end
            // 100 ms then offset, 10 ms then the rest
            strobe_pkg::ST_WAIT_OFS:
               if (cnt_done)
               begin
                  state_q <= strobe_pkg::ST_WAIT_REST;
                  cnt_q <= strobe_pkg::CNT_W'(GAP_CYC - 1);
               end
               else
                  cnt_q <= cnt_q - 24'h000001;
            strobe_pkg::ST_WAIT_REST:
               if (cnt_done)
                  state_q <= strobe_pkg::ST_ACTIVE;
               else
                  cnt_q <= cnt_q - 24'h000001;
            strobe_pkg::ST_ACTIVE:
               state_q <= strobe_pkg::ST_ACTIVE;
            strobe_pkg::ST_FAULT:
               state_q <= strobe_pkg::ST_FAULT;
            default:
               state_q <= strobe_pkg::ST_OFF;
         endcase
      end
   end

   // ----------------------------------------
   // rail outputs
   // ----------------------------------------
   logic ofs_q;
   logic rest_q;
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         ofs_q <= 1'b0;
         rest_q <= 1'b0;
      end
      else
      begin
         ofs_q <= state_q == strobe_pkg::ST_WAIT_REST || state_q == strobe_pkg::ST_ACTIVE;
         rest_q <= state_q == strobe_pkg::ST_ACTIVE;
      end
   end
   // all rails drop together via one state
   assign MIRROR_OFFSET_RAIL = ofs_q && state_q != strobe_pkg::ST_FAULT;
   assign MIRROR_BIAS_RAIL = rest_q && state_q != strobe_pkg::ST_FAULT;
   assign MIRROR_RESET_RAIL = rest_q && state_q != strobe_pkg::ST_FAULT;

   // decoder only after all rails up
   wire logic dec_en = rest_q && state_q == strobe_pkg::ST_ACTIVE && led_en;
   assign LED_DRIVER_EN = dec_en;

   // ----------------------------------------
   // strobe decoder
   // ----------------------------------------
   // map bit picks the package wiring
   wire logic map1 = ctrl_q[strobe_pkg::CTRL_MAP_BIT];
   wire logic [5:0] pat0 = sel == 2'h0 ? strobe_pkg::MAP0_SEL0 :
      sel == 2'h1 ? strobe_pkg::MAP0_SEL1 :
      sel == 2'h2 ? strobe_pkg::MAP0_SEL2 : strobe_pkg::MAP0_SEL3;
   wire logic [5:0] pat1 = sel == 2'h0 ? strobe_pkg::MAP1_SEL0 :
      sel == 2'h1 ? strobe_pkg::MAP1_SEL1 :
      sel == 2'h2 ? strobe_pkg::MAP1_SEL2 : strobe_pkg::MAP1_SEL3;
   wire logic [5:0] target = !dec_en ? strobe_pkg::SW_ALL_OPEN : map1 ? pat1 : pat0;
   wire logic [9:0] code_sel = sel == 2'h1 ? code4_q : sel == 2'h2 ? code5_q : code6_q;
   wire logic code_ok = dec_en && sel != 2'h0;

   // ----------------------------------------
   // current code
   // ----------------------------------------
   // registered so the setpoint never glitches between colours
   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         CURRENT_CODE <= 10'h000;
         CODE_VALID <= 1'b0;
      end
      else
      begin
         CURRENT_CODE <= code_ok ? code_sel : 10'h000;
         CODE_VALID <= code_ok;
      end
   end

   logic bbm_busy;
   bbm_switch u_bbm
   (
      .clk(CLOCK),
      .rst(RST),
      .target(target),
      .dead_cycles(bbm_q),
      .sw_q(LED_SWITCH),
      .busy(bbm_busy)
   );

   // ----------------------------------------
   // read data
   // ----------------------------------------
   wire logic [31:0] status = {24'h000000, bbm_busy, dec_en, rest_q, ofs_q, 1'b0, state_q};
   // unmapped reads return zero alongside the slave error
   wire logic [31:0] rd_mux = at_ctrl ? {29'h00000000, ctrl_q} :
      at_bbm ? {24'h000000, bbm_q} :
      at_code4 ? {22'h000000, code4_q} :
      at_code5 ? {22'h000000, code5_q} :
      at_code6 ? {22'h000000, code6_q} :
      at_status ? status : 32'h00000000;

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         rdata_q <= 32'h00000000;
      else if (rd)
         rdata_q <= rd_mux;
   end
endmodule : strobe_sequencer
`default_nettype wire

// ### verification/strobe_sequencer_asserts.sv
// assertions on the sequencer pins
`timescale 1ns/1ns
`default_nettype none
module strobe_sequencer_asserts
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic POWER_REQUEST_PIN,
   input wire logic RAIL_FAULT,
   input wire logic MIRROR_OFFSET_RAIL,
   input wire logic MIRROR_BIAS_RAIL,
   input wire logic MIRROR_RESET_RAIL,
   input wire logic LED_DRIVER_EN,
   input wire logic [5:0] LED_SWITCH,
   input wire logic CODE_VALID
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // ---------------------------------
   // rail order and gating
   // ---------------------------------
   chk_ofs_late: assert property ($rose(MIRROR_OFFSET_RAIL) |-> $past(POWER_REQUEST_PIN, 300))
      else $error("offset rail early");
   chk_bias_late: assert property ($rose(MIRROR_BIAS_RAIL) |-> $past(MIRROR_OFFSET_RAIL, 300))
      else $error("bias rail early");
   chk_bias_pair: assert property (MIRROR_BIAS_RAIL == MIRROR_RESET_RAIL)
      else $error("bias and reset rails differ");
   chk_drv_gate: assert property (LED_DRIVER_EN |-> MIRROR_OFFSET_RAIL && MIRROR_BIAS_RAIL)
      else $error("driver on before rails");
   chk_fault_drop: assert property ($rose(RAIL_FAULT) |-> ##[1:5] !(MIRROR_OFFSET_RAIL || MIRROR_BIAS_RAIL))
      else $error("rails kept after fault");
   chk_pin_off: assert property (!POWER_REQUEST_PIN [*6] |-> !MIRROR_OFFSET_RAIL)
      else $error("rail on with request low");
   // ---------------------------------
   // switch timing
   // ---------------------------------
   // dead time at least 8 cycles: bench keeps the delay above that
   chk_break_first: assert property (($past(LED_SWITCH) & ~LED_SWITCH) != 6'h00 |-> ((LED_SWITCH & ~$past(LED_SWITCH)) == 6'h00) [*8])
      else $error("switch closed within dead time");
   chk_idle_open: assert property (!MIRROR_BIAS_RAIL && !$past(MIRROR_BIAS_RAIL, 3) |-> LED_SWITCH == 6'h00 && !CODE_VALID)
      else $error("switch closed while decoder off");
   cover property ($rose(LED_DRIVER_EN));
   cover property ($rose(RAIL_FAULT) && MIRROR_BIAS_RAIL);
   cover property (($past(LED_SWITCH) & ~LED_SWITCH) != 6'h00);
endmodule : strobe_sequencer_asserts
bind strobe_sequencer strobe_sequencer_asserts chk_i (.*);
`default_nettype wire

// ### verification/disp_ctrl_model.sv
// display controller stand-in: request pin and colour select
`timescale 1ns/1ns
`default_nettype none
module disp_ctrl_model
(
   input wire logic clk,
   input wire logic pwr,
   input wire logic step,
   input wire logic [1:0] sel,
   output logic pin,
   output logic [1:0] csel
);
   always_ff @(posedge clk)
   begin
      pin <= pwr;
      csel <= step ? ((csel == 2'h3) ? 2'h1 : csel + 2'h1) : sel;
   end
endmodule : disp_ctrl_model
`default_nettype wire

// ### verification/strobe_sequencer_tb_top.sv
// self-checking bench for the strobe sequencer
`timescale 1ns/1ns
`default_nettype none
module strobe_sequencer_tb_top;
   // shortened rail delays so the run stays a few thousand cycles
   localparam int TB_OFS = 2000;
   localparam int TB_GAP = 400;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic fault = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pwr = 1'b0;
   logic step = 1'b0;
   logic [1:0] sel = 2'h0;
   wire logic pin;
   wire logic [1:0] csel;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, ofs, bias, rstr, drv, valid;
   logic [5:0] sw;
   logic [9:0] code;
   int bad_count = 0;
   int num_checks = 0;
   int n;
   // map, colour select, switches, current code
   logic [18:0] rows [8] = '{{1'b0, 2'h0, 6'h07, 10'h000}, {1'b0, 2'h1, 6'h0F, 10'h111},
      {1'b0, 2'h2, 6'h17, 10'h222}, {1'b0, 2'h3, 6'h27, 10'h333}, {1'b1, 2'h0, 6'h00, 10'h000},
      {1'b1, 2'h1, 6'h21, 10'h111}, {1'b1, 2'h2, 6'h1C, 10'h222}, {1'b1, 2'h3, 6'h1A, 10'h333}};
   disp_ctrl_model ctrl_i (.clk(clock), .pwr(pwr), .step(step), .sel(sel), .pin(pin), .csel(csel));
   strobe_sequencer #(.OFS_CYC(TB_OFS), .GAP_CYC(TB_GAP)) uut (.CLOCK(clock), .RST(rst),
      .POWER_REQUEST_PIN(pin), .COLOUR_SELECT(csel),
      .RAIL_FAULT(fault), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MIRROR_OFFSET_RAIL(ofs), .MIRROR_BIAS_RAIL(bias), .MIRROR_RESET_RAIL(rstr),
      .LED_DRIVER_EN(drv), .LED_SWITCH(sw), .CURRENT_CODE(code), .CODE_VALID(valid));
   initial
   begin
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   // ---------------------------------
   // watchdog
   // ---------------------------------
   // tests need about 3,300 cycles; 10,000 leaves ample margin
   initial
   begin
      #100_000;
      bad_count++;
      end_sim();
   end
   initial
   begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h6);
      apb(1'b0, 8'h18, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      apb(1'b1, 8'h08, 32'h111);
      apb(1'b1, 8'h0C, 32'h222);
      apb(1'b1, 8'h10, 32'h333);
      apb(1'b1, 8'h04, 32'h20);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h111);
      apb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h20);
      $display("registers done");
      pwr <= 1'b1;
      n = 0;
      while (ofs !== 1'b1)
      begin
         @(posedge clock);
         n++;
      end
      check(n >= TB_OFS && n <= TB_OFS + 8, 1);
      check({bias, drv}, 2'h0);
      n = 0;
      while (bias !== 1'b1)
      begin
         @(posedge clock);
         n++;
      end
      check(n >= TB_GAP - 2 && n <= TB_GAP + 2, 1);
      repeat (3) @(posedge clock);
      check({rstr, drv}, 2'h3);
      apb(1'b0, 8'h14, 32'h0);
      check(rd, 32'h73);
      $display("power-up done");
      foreach (rows[i])
      begin
         apb(1'b1, 8'h00, {29'h0, 2'h3, rows[i][18]});
         sel <= rows[i][17:16];
         repeat (80) @(posedge clock);
         check(sw, rows[i][15:10]);
         check({valid, code}, {rows[i][9:0] != 10'h000, rows[i][9:0]});
         $display("row %0d done", i);
      end
      apb(1'b1, 8'h00, 32'h6);
      sel <= 2'h1;
      repeat (80) @(posedge clock);
      step <= 1'b1;
      sel <= 2'h2;
      @(posedge clock);
      step <= 1'b0;
      while (sw !== 6'h07) @(posedge clock);
      n = 0;
      while (sw === 6'h07)
      begin
         @(posedge clock);
         n++;
      end
      check(n >= 32'h1F && n <= 32'h23, 1);
      check(sw, 6'h17);
      $display("dead time done");
      fault <= 1'b1;
      repeat (8) @(posedge clock);
      check({ofs, bias, rstr, drv, sw}, 10'h000);
      fault <= 1'b0;
      pwr <= 1'b0;
      repeat (8) @(posedge clock);
      check({ofs, valid}, 2'h0);
      $display("fault done");
      end_sim();
   end
endmodule : strobe_sequencer_tb_top
`default_nettype wire
